/* File: rtl/lbc_pkg.sv */
// package for the local bus cycle control block
// assumes one system clock; all bus timing counted in its phases
package lbc_pkg;
    // **************************************************
    // widths and timing
    // **************************************************
    localparam int LBC_DATA_W = 16;
    localparam int LBC_ADDR_W = 24;
    localparam int LBC_QUEUE_BYTES = 6;
    localparam int LBC_FETCH_ROOM = 2;
    localparam int LBC_QCNT_W = 3;
    localparam logic [LBC_QCNT_W-1:0] LBC_QCNT_ZERO = 3'h0;
    localparam logic [LBC_QCNT_W-1:0] LBC_QCNT_ONE = 3'h1;
    localparam logic [LBC_QCNT_W-1:0] LBC_QCNT_TWO = 3'h2;
    localparam logic LBC_PH1 = 1'b0;
    localparam logic LBC_PH2 = 1'b1;
    localparam logic [LBC_ADDR_W-1:0] LBC_ADDR_ZERO = 24'h000000;
    localparam logic [LBC_ADDR_W-1:0] LBC_ADDR_TWO = 24'h000002;
    localparam logic [LBC_ADDR_W-1:0] LBC_ADDR_ONE = 24'h000001;
    localparam logic [LBC_DATA_W-1:0] LBC_DATA_ZERO = 16'h0000;
    // bus status codes, active low, 2'b11 = inactive
    localparam logic [1:0] LBC_ST_IDLE = 2'h3;
    localparam logic [1:0] LBC_ST_WRITE = 2'h2;
    localparam logic [1:0] LBC_ST_READ = 2'h1;

    // **************************************************
    // types
    // **************************************************
    typedef enum logic [1:0] {
        LBC_TI = 2'b00,
        LBC_TS = 2'b01,
        LBC_TC = 2'b10,
        LBC_TH = 2'b11
    } lbc_state_t;

    // one request from the execution side
    typedef struct packed {
        logic valid;
        logic write;
        logic locked;
        logic last_locked;
        logic interrupt_acknowledge_cycle;
        logic [LBC_ADDR_W-1:0] addr;
        logic [LBC_DATA_W-1:0] wdata;
    } lbc_req_t;

    // pins toward the local bus
    typedef struct packed {
        logic [1:0] status_n;
        logic lock_n;
        logic data_direction_out;
        logic bus_grant_out;
        logic [LBC_ADDR_W-1:0] addr;
        logic [LBC_DATA_W-1:0] data_out;
        logic data_oe_n;
    } lbc_bus_t;
endpackage

/* File: rtl/lbc_fetch.sv */
// prefetch request generator for the local bus cycle control block
// assumes the bus engine reports each completed fetch through take
`timescale 1ns/10ps
`default_nettype none
module lbc_fetch (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic take,
    input wire logic consume,
    input wire logic branch,
    input wire logic [lbc_pkg::LBC_ADDR_W-1:0] branch_addr,
    input wire logic stop_decoded,
    input wire logic protected_mode,
    input wire logic [lbc_pkg::LBC_ADDR_W-1:0] seg_limit,
    output logic want,
    output logic byte_fetch,
    output logic [lbc_pkg::LBC_ADDR_W-1:0] fetch_addr,
    output logic [lbc_pkg::LBC_QCNT_W-1:0] queue_fill
);
    import lbc_pkg::*;

    typedef struct packed {
        logic [LBC_QCNT_W-1:0] fill;
        logic [LBC_ADDR_W-1:0] addr;
        logic stopped;
    } lbc_fst_t;

    lbc_fst_t st_r, st_nxt;
    logic room;
    logic past_limit;

    // **************************************************
    // fetch decision
    // **************************************************
    // free space in the queue and the code segment end
    assign room = (3'(LBC_QUEUE_BYTES) - st_r.fill) >= 3'(LBC_FETCH_ROOM);
    assign past_limit = protected_mode && (st_r.addr > seg_limit);
    assign want = room && !st_r.stopped && !past_limit;
    assign byte_fetch = st_r.addr[0];
    assign fetch_addr = st_r.addr;
    assign queue_fill = st_r.fill;

    // next state of queue and fetch pointer
    always_comb begin
        st_nxt = st_r;
        if (take) begin
            st_nxt.fill = st_r.fill + (st_r.addr[0] ? LBC_QCNT_ONE : LBC_QCNT_TWO);
            st_nxt.addr = st_r.addr + (st_r.addr[0] ? LBC_ADDR_ONE : LBC_ADDR_TWO);
        end
        if (consume && st_nxt.fill != LBC_QCNT_ZERO) begin
            st_nxt.fill = st_nxt.fill - LBC_QCNT_ONE;
        end
        if (stop_decoded) begin
            st_nxt.stopped = 1'b1;
        end
        if (branch) begin
            st_nxt.addr = branch_addr;
            st_nxt.fill = LBC_QCNT_ZERO;
            st_nxt.stopped = 1'b0;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_r <= '{fill: LBC_QCNT_ZERO, addr: LBC_ADDR_ZERO, stopped: 1'b0};
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // an odd fetch moves the pointer on by one byte only
    AST_ODD_BYTE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && take && !branch && byte_fetch)
        |=> (fetch_addr == $past(fetch_addr) + LBC_ADDR_ONE))
        else $error("odd fetch not byte");
    AST_STOP: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && stop_decoded && !branch) |=> !want) else $error("fetch after stop");
endmodule
`default_nettype wire

/* File: rtl/lbc_top.sv */
// processor side bus cycle sequencer with prefetch
// assumes ready_n is synchronous to ref_clk and all inputs are clean
`timescale 1ns/10ps
`default_nettype none
module lbc_top (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic ready_n,
    input wire logic hold_req,
    input wire lbc_pkg::lbc_req_t exec_req,
    input wire logic consume,
    input wire logic branch,
    input wire logic [lbc_pkg::LBC_ADDR_W-1:0] branch_addr,
    input wire logic stop_decoded,
    input wire logic protected_mode,
    input wire logic [lbc_pkg::LBC_ADDR_W-1:0] seg_limit,
    input wire logic [lbc_pkg::LBC_DATA_W-1:0] data_in,
    output logic exec_done,
    output logic [lbc_pkg::LBC_DATA_W-1:0] rdata,
    output logic [lbc_pkg::LBC_QCNT_W-1:0] queue_fill,
    output lbc_pkg::lbc_bus_t bus
);
    import lbc_pkg::*;

    typedef struct packed {
        logic phase;
        lbc_state_t state;
        logic cur_write;
        logic cur_fetch;
        logic cur_interrupt_acknowledge_cycle;
        logic cur_last;
        logic first_tc;
        logic hold_gap;
        logic drop_drive;
        logic [LBC_DATA_W-1:0] rdata;
        lbc_bus_t bus;
    } lbc_st_t;

    lbc_st_t st_r, st_nxt;
    logic fetch_want;
    logic fetch_byte;
    logic [LBC_ADDR_W-1:0] fetch_addr;
    logic fetch_take;
    logic clock_end;
    logic cyc_end;
    logic start_exec;
    logic start_fetch;

    // **************************************************
    // prefetcher
    // **************************************************
    lbc_fetch u_fetch (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .take(fetch_take),
        .consume(consume),
        .branch(branch),
        .branch_addr(branch_addr),
        .stop_decoded(stop_decoded),
        .protected_mode(protected_mode),
        .seg_limit(seg_limit),
        .want(fetch_want),
        .byte_fetch(fetch_byte),
        .fetch_addr(fetch_addr),
        .queue_fill(queue_fill)
    );

    // **************************************************
    // sequencer
    // **************************************************
    // processor clock ends on every phase 2 edge
    assign clock_end = (st_r.phase == LBC_PH2);
    // last command state ends when ready is seen at the end of it
    assign cyc_end = clock_end && st_r.state == LBC_TC && !ready_n;
    assign start_exec = exec_req.valid && !st_r.hold_gap && !hold_req;
    // no fetch on an edge that retires a fetch, flushes or stops: queue state is stale then
    assign start_fetch = fetch_want && !exec_req.valid && !hold_req && !st_r.hold_gap
                         && !fetch_take && !branch && !stop_decoded;
    assign fetch_take = cyc_end && st_r.cur_fetch;
    // done marks the edge that ends the cycle; a request still valid at that edge starts another cycle unless hold_req is high
    assign exec_done = clk_en && cyc_end && !st_r.cur_fetch;
    assign rdata = st_r.rdata;
    assign bus = st_r.bus;

    always_comb begin
        logic may_start;
        may_start = 1'b0;
        st_nxt = st_r;
        st_nxt.phase = ~st_r.phase;
        // status only stands for send-status
        if (st_r.state == LBC_TS && clock_end) begin
            st_nxt.bus.status_n = LBC_ST_IDLE;
        end
        // write data appears in phase 2 of send-status
        if (st_r.state == LBC_TS && !clock_end && st_r.cur_write) begin
            st_nxt.bus.data_oe_n = 1'b0;
            // value loads here so an earlier write keeps its data for its hold phase
            st_nxt.bus.data_out = exec_req.wdata;
        end
        // lock drops after the first command state where asked
        if (st_r.state == LBC_TC && clock_end && st_r.first_tc) begin
            st_nxt.first_tc = 1'b0;
            if (st_r.cur_interrupt_acknowledge_cycle || st_r.cur_last) begin
                st_nxt.bus.lock_n = 1'b1;
            end
        end
        // float after write in phase 2 of following clock
        if (st_r.drop_drive && !clock_end) begin
            st_nxt.bus.data_oe_n = 1'b1;
            st_nxt.drop_drive = 1'b0;
        end
        if (clock_end) begin
            unique case (st_r.state)
                LBC_TI, LBC_TH: begin
                    may_start = 1'b1;
                    st_nxt.hold_gap = 1'b0;
                    // hold_gap only keeps new cycles off; the grant follows the one idle clock
                    if (hold_req) begin
                        st_nxt.state = LBC_TH;
                        st_nxt.bus.bus_grant_out = 1'b1;
                    end else begin
                        st_nxt.state = LBC_TI;
                        st_nxt.bus.bus_grant_out = 1'b0;
                    end
                end
                LBC_TS: begin
                    st_nxt.state = LBC_TC;
                    st_nxt.first_tc = 1'b1;
                end
                LBC_TC: begin
                    if (!ready_n) begin
                        st_nxt.rdata = st_r.cur_write ? st_r.rdata : data_in;
                        // data is held through phase 1 of the next clock, then floated unless reused
                        st_nxt.drop_drive = st_r.cur_write;
                        st_nxt.state = LBC_TI;
                        if (st_r.cur_write && hold_req) begin
                            st_nxt.hold_gap = 1'b1;
                        end else begin
                            may_start = 1'b1;
                        end
                    end
                end
            endcase
            if (may_start && (start_exec || start_fetch)) begin
                st_nxt.state = LBC_TS;
                st_nxt.bus.bus_grant_out = 1'b0;
                st_nxt.cur_fetch = !start_exec;
                st_nxt.cur_write = start_exec && exec_req.write;
                st_nxt.cur_interrupt_acknowledge_cycle = start_exec && exec_req.interrupt_acknowledge_cycle;
                st_nxt.cur_last = start_exec && exec_req.last_locked;
                st_nxt.bus.addr = start_exec ? exec_req.addr : fetch_addr;
                st_nxt.bus.status_n = (start_exec && exec_req.write) ? LBC_ST_WRITE
                                                                     : LBC_ST_READ;
                st_nxt.bus.data_direction_out = start_exec && exec_req.write;
                st_nxt.bus.lock_n = !(start_exec && (exec_req.locked || exec_req.interrupt_acknowledge_cycle));
                if (start_exec && exec_req.write) begin
                    // write after write keeps driving; the release just planned is cancelled
                    st_nxt.drop_drive = 1'b0;
                end
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_r <= '{phase: LBC_PH1, state: LBC_TI, cur_write: 1'b0, cur_fetch: 1'b0,
                      cur_interrupt_acknowledge_cycle: 1'b0, cur_last: 1'b0, first_tc: 1'b0, hold_gap: 1'b0,
                      drop_drive: 1'b0, rdata: LBC_DATA_ZERO,
                      bus: '{status_n: LBC_ST_IDLE, lock_n: 1'b1, data_direction_out: 1'b1,
                             bus_grant_out: 1'b0, addr: LBC_ADDR_ZERO,
                             data_out: LBC_DATA_ZERO, data_oe_n: 1'b1}};
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // **************************************************
    // checks
    // **************************************************
    sequence s_ts_end;
        clk_en && st_r.state == LBC_TS && clock_end;
    endsequence
    AST_STATUS_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_ts_end |=> (bus.status_n == LBC_ST_IDLE)) else $error("status stayed");
    AST_TS_TO_TC: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_ts_end |=> (st_r.state == LBC_TC)) else $error("no command state");
    AST_PHASE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        clk_en |=> (st_r.phase != $past(st_r.phase))) else $error("phase stuck");
    AST_STATE_LEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && !clock_end) |=> (st_r.state == $past(st_r.state))) else $error("half state");
    AST_WDATA_PH2: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && st_r.state == LBC_TS && !clock_end && st_r.cur_write) |=> !bus.data_oe_n)
        else $error("write data late");
    AST_READ_DIR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_r.state == LBC_TS && !st_r.cur_write) |-> !bus.data_direction_out)
        else $error("read direction");
    AST_HOLD_GAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && cyc_end && st_r.cur_write && hold_req) |=> (st_r.state == LBC_TI))
        else $error("no idle before grant");
    AST_WRITE_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && cyc_end && st_r.cur_write) |=> (!bus.data_oe_n && $stable(bus.data_out)))
        else $error("data hold lost");
    AST_INTERRUPT_ACKNOWLEDGE_CYCLE_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && st_r.state == LBC_TC && clock_end && st_r.first_tc && st_r.cur_interrupt_acknowledge_cycle)
        |=> bus.lock_n) else $error("lock not dropped");
endmodule
`default_nettype wire

/* File: verification/lbc_mem_model.sv */
// memory and ready source model facing the local bus cycle control block
// assumes the bench sets the wait count before each cycle starts
`timescale 1ns/10ps
`default_nettype none
module lbc_mem_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire lbc_pkg::lbc_bus_t bus,
    input wire logic [3:0] waits,
    input wire logic [lbc_pkg::LBC_DATA_W-1:0] rd_word,
    output logic ready_n,
    output logic [lbc_pkg::LBC_DATA_W-1:0] data_in
);
    import lbc_pkg::*;
    // *****************************************
    // cycle tracking from status start
    // *****************************************
    logic [4:0] cnt_r;
    logic last_w;
    logic command_delay_in;
    logic cmd_on_r;
    // last command cycle lands after the requested number of wait states
    assign last_w = (cnt_r == 5'h03 + {waits, 1'b0});
    // counter restarts on every new status, runs on the system clock only
    always_ff @(posedge ref_clk) begin
        if (!rst_b || last_w) begin
            cnt_r <= 5'h00;
        end else if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r + 5'h01;
        end else if (bus.status_n != LBC_ST_IDLE) begin
            cnt_r <= 5'h01;
        end
    end
    // command delay holds the command back one clock on cycles with wait states
    assign command_delay_in = (cnt_r == 5'h02) && (waits != 4'h0);
    // command goes active on the first falling edge after send-status with delay low
    always_ff @(negedge ref_clk) begin
        if (!rst_b || cnt_r == 5'h00) begin
            cmd_on_r <= 1'b0;
        end else if (cnt_r >= 5'h02 && !cmd_on_r && !command_delay_in) begin
            cmd_on_r <= 1'b1;
        end
    end
    // ready only with an active command; data inverted when not answering
    assign ready_n = !(last_w && cmd_on_r);
    assign data_in = last_w ? rd_word : ~rd_word;
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the local bus cycle control block
// assumes lbc_pkg, lbc_top and lbc_mem_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import lbc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic ready_n, exec_done;
    logic hold_req = 1'b0, consume = 1'b0, branch = 1'b0, stop_decoded = 1'b0;
    logic protected_mode = 1'b0;
    logic [LBC_ADDR_W-1:0] branch_addr = LBC_ADDR_ZERO;
    logic [LBC_ADDR_W-1:0] seg_limit = 24'hFFFFFF;
    logic [LBC_DATA_W-1:0] data_in, rdata;
    logic [LBC_DATA_W-1:0] rd_word = 16'hA5C3;
    logic [LBC_QCNT_W-1:0] queue_fill;
    logic [3:0] waits = 4'h0;
    lbc_req_t exec_req = '0;
    lbc_bus_t bus;
    int fails = 0, samples_checked = 0, cycles = 0, cyc, st, lkc, oe_hi;
    logic dir_seen;
    logic oe_hist [0:31];
    logic [LBC_ADDR_W-1:0] addrs [$];
    logic [1:0] st_prev = 2'h3;
    logic [2:0] lock_kinds [0:2] = '{3'h5, 3'h6, 3'h4};

    lbc_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .ready_n(ready_n),
        .hold_req(hold_req), .exec_req(exec_req), .consume(consume), .branch(branch),
        .branch_addr(branch_addr), .stop_decoded(stop_decoded),
        .protected_mode(protected_mode), .seg_limit(seg_limit), .data_in(data_in),
        .exec_done(exec_done), .rdata(rdata), .queue_fill(queue_fill), .bus(bus));
    lbc_mem_model u_mem (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .waits(waits),
        .rd_word(rd_word), .ready_n(ready_n), .data_in(data_in));

    // *****************************************
    // clock, start monitor and hang limit
    // *****************************************
    always #25 ref_clk = ~ref_clk;
    // record the address of every new bus cycle
    always @(posedge ref_clk) begin
        st_prev <= bus.status_n;
        if (bus.status_n !== LBC_ST_IDLE && st_prev === LBC_ST_IDLE) addrs.push_back(bus.addr);
        cycles++;
        if (cycles == 6000) begin
            fails++;
            wrap_up();
        end
    end

    // *****************************************
    // shared tasks
    // *****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask
    // one execution cycle; flags are locked, last locked, acknowledge
    task automatic run_op(input int w, input logic wr, input logic [2:0] fl, input logic hd,
        input logic keep);
        logic started;
        started = 1'b0;
        waits = w[3:0];
        exec_req.write = wr;
        {exec_req.locked, exec_req.last_locked, exec_req.interrupt_acknowledge_cycle} = fl;
        exec_req.addr = 24'h000300;
        exec_req.wdata = rd_word;
        exec_req.valid = 1'b1;
        cyc = 0;
        st = 0;
        lkc = 0;
        oe_hi = 0;
        // done is seen in the last command cycle, while the request still stands
        for (int i = 0; i < 60; i++) begin
            tick(1);
            if (bus.status_n !== LBC_ST_IDLE) begin
                if (!started) dir_seen = bus.data_direction_out;
                started = 1'b1;
                st++;
            end
            if (started) begin
                oe_hist[cyc] = bus.data_oe_n;
                cyc++;
                lkc += (bus.lock_n === 1'b0);
            end
            oe_hi += (bus.data_oe_n !== 1'b0);
            if (hd && cyc == 2) hold_req = 1'b1;
            if (exec_done === 1'b1) break;
        end
        chk("exec_done", 1, exec_done);
        if (!keep) exec_req.valid = 1'b0;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // *****************************************
    // scenarios
    // *****************************************
    task automatic t_fill();
        addrs.delete();
        for (int i = 0; i < 200 && queue_fill !== 3'h6; i++) tick(1);
        tick(20);
        chk("queue_fill", LBC_QUEUE_BYTES, queue_fill);
        chk("word fetch count", 3, addrs.size());
    endtask
    task automatic t_odd();
        addrs.delete();
        branch_addr = 24'h000101;
        pulse(branch);
        tick(80);
        chk("odd target", 24'h000101, addrs[0]);
        chk("after byte fetch", 24'h000102, addrs[1]);
        chk("fill below room", 5, queue_fill);
    endtask
    task automatic t_stop();
        pulse(stop_decoded);
        repeat (3) pulse(consume);
        addrs.delete();
        tick(30);
        chk("stopped fetches", 0, addrs.size());
        chk("fill after consume", 2, queue_fill);
    endtask
    task automatic t_prot();
        protected_mode = 1'b1;
        seg_limit = 24'h000203;
        branch_addr = 24'h000200;
        addrs.delete();
        pulse(branch);
        tick(80);
        chk("fetches in segment", 2, addrs.size());
        chk("fill at limit", 4, queue_fill);
    endtask
    task automatic t_read();
        for (int w = 0; w < 3; w++) begin
            rd_word = 16'hA5C3 ^ w[15:0];
            run_op(w, 1'b0, 3'h0, 1'b0, 1'b0);
            chk("read length", 4 + 2 * w, cyc);
            chk("status span", 2, st);
            chk("read direction", 0, dir_seen);
            tick(1);
            chk("read data", rd_word, rdata);
        end
    endtask
    task automatic t_write();
        run_op(1, 1'b1, 3'h0, 1'b0, 1'b0);
        chk("write direction", 1, dir_seen);
        chk("data off in first phase", 1, oe_hist[0]);
        chk("data on in second phase", 0, oe_hist[1]);
        tick(1);
        chk("data hold", 0, bus.data_oe_n);
        chk("data hold value", rd_word, bus.data_out);
        tick(1);
        chk("data released", 1, bus.data_oe_n);
    endtask
    task automatic t_ww();
        run_op(0, 1'b1, 3'h0, 1'b0, 1'b1);
        rd_word = 16'h3C96;
        run_op(0, 1'b1, 3'h0, 1'b0, 1'b0);
        chk("write gap", 0, oe_hi);
        chk("second data", 16'h3C96, bus.data_out);
        tick(1);
    endtask
    task automatic t_hold();
        int n;
        run_op(1, 1'b1, 3'h0, 1'b1, 1'b0);
        n = 0;
        while (bus.bus_grant_out !== 1'b1 && n < 12) begin
            tick(1);
            n++;
        end
        chk("idle before grant", 3, n);
        chk("grant", 1, bus.bus_grant_out);
        chk("released bus", 1, bus.data_oe_n);
        hold_req = 1'b0;
        tick(6);
        chk("grant dropped", 0, bus.bus_grant_out);
    endtask
    task automatic t_lock();
        for (int k = 0; k < 3; k++) begin
            run_op(2, 1'b0, lock_kinds[k], 1'b0, 1'b0);
            chk("lock span", k < 2 ? 4 : 8, lkc);
            tick(1);
        end
    endtask

    // *****************************************
    // main sequence
    // *****************************************
    initial begin
        tick(2);
        rst_b = 1'b1;
        t_fill();
        t_odd();
        t_stop();
        t_prot();
        t_read();
        t_write();
        t_ww();
        t_hold();
        t_lock();
        wrap_up();
    end
endmodule
`default_nettype wire
